// ==== logic/dq_defines.vh ====
// Constants for the queue engine.
// Functional notes
// - Last page entry is link; engine follows it.
// - Tail write starts work; head reports progress.
// - Bits 63:0 hold the read-from address.
// - Bits 127:64 hold the written-to address.
// - Bit 255 set means next-page link entry.
// - Length bits 147:128; zero means one megabyte.
// - Identifier bits 175:160 go to completed index.
// - Notify only when global and descriptor enables.
// - Writeback sends identifier to consumed-head address.
// - Upstream bits 211:192 receive actual byte count.
// - Bit 222 starts a new downstream packet.
// - Start and end may share or span descriptors.
// - Bit 223 marks last beat of descriptor data.
// - Upstream packet end writes end flag, count.
// - Early end then more data: next gets start.
// - Stale descriptors (bit 254) are never processed.
// - Metadata replaces device-side address when enabled.
// - First upstream data writes start flag, then notify.
// - Upstream data without tail update is dropped.
`ifndef DQ_DEFINES_VH
`define DQ_DEFINES_VH

// ==========================================================
// Register offsets
`define DQ_REG_CTRL 8'h00
`define DQ_REG_BASE_LO 8'h08
`define DQ_REG_BASE_HI 8'h0c
`define DQ_REG_TAIL 8'h10
`define DQ_REG_HEAD 8'h14
`define DQ_REG_COMPLETED 8'h18
`define DQ_REG_CONS_LO 8'h20
`define DQ_REG_CONS_HI 8'h24
`define DQ_REG_PAYLOAD 8'h44

// ==========================================================
// Control register bits
`define DQ_CTRL_ENABLE 0
`define DQ_CTRL_GLB_IRQ 1
`define DQ_CTRL_GLB_WB 2
`define DQ_CTRL_D2H 3
`define DQ_CTRL_STREAM 4
`define DQ_CTRL_META 5
`define DQ_CTRL_RESET 6'h00
`define DQ_PAYLOAD_RESET 32'h0000_0000

// ==========================================================
// Descriptor layout
`define DQ_DESC_LINK 255
`define DQ_DESC_STALE 254
`define DQ_DESC_EOF 223
`define DQ_DESC_SOF 222
`define DQ_DESC_RSV_HI 221
`define DQ_DESC_RSV_LO 212
`define DQ_DESC_WB 177
`define DQ_DESC_IRQ 176
`define DQ_DESC_ID_HI 175
`define DQ_DESC_ID_LO 160
`define DQ_DESC_LEN_HI 147
`define DQ_DESC_LEN_LO 128
`define DQ_DESC_DST_HI 127
`define DQ_DESC_DST_LO 64
`define DQ_DESC_SRC_HI 63
`define DQ_DESC_SRC_LO 0
`define DQ_DESC_BYTES 64'h0000_0000_0000_0020
`define DQ_DESC_FLAGS_OFS 64'h0000_0000_0000_0018
`define DQ_LEN_ONE_MB 21'h10_0000

`endif

// ==== logic/two_entry_buffer.v ====
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter W = 8
) (
  input wire clk_sys,
  input wire reset_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:1];
  reg wr_ptr_r;
  reg rd_ptr_r;
  reg [1:0] count_r;
  wire push;
  wire pop;

  assign in_ready = (count_r != 2'd2);
  assign out_valid = (count_r != 2'd0);
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      if (push && !pop) begin
        count_r <= count_r + 2'd1;
      end else if (pop && !push) begin
        count_r <= count_r - 2'd1;
      end
    end
  end
endmodule

// ==== logic/desc_field_decode.v ====
// Field decoder for one 32-byte queue descriptor.
`timescale 1ns/1ps
`include "dq_defines.vh"
module desc_field_decode (
  input wire [255:0] desc,
  input wire d2h,
  input wire meta_en,
  output wire is_link,
  output wire is_stale,
  output wire [63:0] read_from_address_field,
  output wire [63:0] write_to_address_field,
  output wire [63:0] metadata,
  output wire [20:0] length_bytes,
  output wire [15:0] descriptor_identifier_field,
  output wire irq_en,
  output wire per_descriptor_status_write_enable,
  output wire sof,
  output wire eof,
  output wire [9:0] reserved_keep
);
  wire [19:0] len_raw;

  assign is_link = desc[`DQ_DESC_LINK];
  assign is_stale = desc[`DQ_DESC_STALE];
  assign read_from_address_field = desc[`DQ_DESC_SRC_HI:`DQ_DESC_SRC_LO];
  assign write_to_address_field = desc[`DQ_DESC_DST_HI:`DQ_DESC_DST_LO];
  // Device-side field carries metadata: low field upstream, high field downstream.
  assign metadata = !meta_en ? 64'h0 :
    (d2h ? read_from_address_field : write_to_address_field);
  assign len_raw = desc[`DQ_DESC_LEN_HI:`DQ_DESC_LEN_LO];
  assign length_bytes = (len_raw == 20'h0) ? `DQ_LEN_ONE_MB : {1'b0, len_raw};
  assign descriptor_identifier_field = desc[`DQ_DESC_ID_HI:`DQ_DESC_ID_LO];
  assign irq_en = desc[`DQ_DESC_IRQ];
  assign per_descriptor_status_write_enable = desc[`DQ_DESC_WB];
  assign sof = desc[`DQ_DESC_SOF];
  assign eof = desc[`DQ_DESC_EOF];
  assign reserved_keep = desc[`DQ_DESC_RSV_HI:`DQ_DESC_RSV_LO];
endmodule

// ==== logic/dma_descriptor_queue_engine.v ====
// Descriptor queue engine: fetch, decode, streaming, notifications.
`timescale 1ns/1ps
`include "dq_defines.vh"
module dma_descriptor_queue_engine #(
  parameter DATA_W = 256,
  parameter BEAT_BYTES = 32
) (
  input wire clk_sys,
  input wire reset_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata_r,
  output reg desc_rd_valid_r,
  input wire desc_rd_ready,
  output reg [63:0] desc_rd_addr_r,
  input wire desc_in_valid,
  input wire [255:0] desc_in_data,
  output reg xfer_valid_r,
  input wire xfer_ready,
  output reg [63:0] xfer_src_r,
  output reg [63:0] xfer_dst_r,
  output reg [20:0] xfer_len_r,
  input wire xfer_done,
  output reg mwr_valid_r,
  input wire mwr_ready,
  output reg [63:0] mwr_addr_r,
  output reg [31:0] mwr_data_r,
  output reg msix_req_r,
  input wire msix_ack,
  input wire h2d_in_valid,
  output wire h2d_in_ready,
  input wire [DATA_W-1:0] h2d_in_data,
  output wire h2d_user_valid,
  input wire h2d_user_ready,
  output wire [DATA_W-1:0] h2d_user_data,
  output wire h2d_user_sop,
  output wire downstream_stream_last_beat,
  output wire [63:0] h2d_user_metadata,
  input wire d2h_user_valid,
  output wire d2h_user_ready,
  input wire [DATA_W-1:0] d2h_user_data,
  input wire upstream_stream_last_beat,
  output wire d2h_out_valid,
  input wire d2h_out_ready,
  output wire [DATA_W-1:0] d2h_out_data,
  output reg [63:0] d2h_metadata_r
);
  localparam [3:0] ST_IDLE = 4'd0;
  localparam [3:0] ST_FETCH = 4'd1;
  localparam [3:0] ST_WAITD = 4'd2;
  localparam [3:0] ST_DECODE = 4'd3;
  localparam [3:0] ST_CMD = 4'd4;
  localparam [3:0] ST_H2D = 4'd5;
  localparam [3:0] ST_MM = 4'd6;
  localparam [3:0] ST_DWAIT = 4'd7;
  localparam [3:0] ST_DDATA = 4'd8;
  localparam [3:0] ST_DUPD = 4'd9;
  localparam [3:0] ST_WB = 4'd10;
  localparam [3:0] ST_MSI = 4'd11;
  localparam [3:0] ST_NEXT = 4'd12;
  localparam [20:0] BEAT = BEAT_BYTES;

  // ==========================================================
  // Queue registers
  reg [5:0] ctrl_r;
  reg [63:0] base_r;
  reg [63:0] cons_r;
  reg [15:0] tail_r;
  reg [15:0] head_r;
  reg [15:0] completed_r;
  reg [31:0] stream_fixed_payload_size;
  reg tail_seen_r;
  reg [3:0] state_r;
  reg [63:0] cur_addr_r;
  reg [255:0] desc_r;
  reg [20:0] remain_r;
  reg [20:0] rx_cnt_r;
  reg first_beat_r;
  reg pkt_open_r;
  reg upd_sof_r;
  reg end_by_last_r;
  reg drop_r;
  reg msix_done_r;

  wire en = ctrl_r[`DQ_CTRL_ENABLE];
  wire d2h = ctrl_r[`DQ_CTRL_D2H];
  wire stream = ctrl_r[`DQ_CTRL_STREAM];
  wire is_link;
  wire is_stale;
  wire [63:0] f_src;
  wire [63:0] f_dst;
  wire [63:0] f_meta;
  wire [20:0] f_len;
  wire [15:0] f_id;
  wire f_irq;
  wire f_wb;
  wire f_sof;
  wire f_eof;
  wire [9:0] f_rsv;

  desc_field_decode u_dec (
    .desc(desc_r),
    .d2h(d2h),
    .meta_en(ctrl_r[`DQ_CTRL_META] && stream),
    .is_link(is_link),
    .is_stale(is_stale),
    .read_from_address_field(f_src),
    .write_to_address_field(f_dst),
    .metadata(f_meta),
    .length_bytes(f_len),
    .descriptor_identifier_field(f_id),
    .irq_en(f_irq),
    .per_descriptor_status_write_enable(f_wb),
    .sof(f_sof),
    .eof(f_eof),
    .reserved_keep(f_rsv)
  );

  // Both the queue-wide and the descriptor's own enable must be set.
  wire wb_on = ctrl_r[`DQ_CTRL_GLB_WB] && f_wb;
  wire irq_on = ctrl_r[`DQ_CTRL_GLB_IRQ] && f_irq;

  // ==========================================================
  // Downstream data path
  wire h2d_take_en = (state_r == ST_H2D);
  wire h2d_buf_ready;
  wire h2d_sop_tag = first_beat_r && f_sof;
  wire h2d_last_tag = (remain_r <= BEAT) && f_eof;
  wire h2d_fire = h2d_in_valid && h2d_in_ready;

  assign h2d_in_ready = h2d_buf_ready && h2d_take_en;

  two_entry_buffer #(.W(DATA_W + 66)) u_h2d_buf (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(h2d_in_valid && h2d_take_en),
    .in_ready(h2d_buf_ready),
    .in_data({h2d_sop_tag, h2d_last_tag, f_meta, h2d_in_data}),
    .out_valid(h2d_user_valid),
    .out_ready(h2d_user_ready),
    .out_data({h2d_user_sop, downstream_stream_last_beat, h2d_user_metadata, h2d_user_data})
  );

  // ==========================================================
  // Upstream data path
  // Packets before any tail update are swallowed to their last beat.
  wire drop_now = stream && d2h && (!tail_seen_r || drop_r);
  wire d2h_buf_ready;
  wire d2h_take_en = (state_r == ST_DDATA) && !drop_now;
  wire d2h_fire = d2h_user_valid && d2h_buf_ready && d2h_take_en;
  wire d2h_drop_fire = d2h_user_valid && drop_now;
  wire [20:0] rx_next = rx_cnt_r + BEAT;

  assign d2h_user_ready = drop_now || (d2h_buf_ready && d2h_take_en);

  two_entry_buffer #(.W(DATA_W)) u_d2h_buf (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(d2h_user_valid && d2h_take_en),
    .in_ready(d2h_buf_ready),
    .in_data(d2h_user_data),
    .out_valid(d2h_out_valid),
    .out_ready(d2h_out_ready),
    .out_data(d2h_out_data)
  );

  // ==========================================================
  // Register access
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_r <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `DQ_REG_CTRL: reg_rdata_r <= {26'h0, ctrl_r};
        `DQ_REG_BASE_LO: reg_rdata_r <= base_r[31:0];
        `DQ_REG_BASE_HI: reg_rdata_r <= base_r[63:32];
        `DQ_REG_TAIL: reg_rdata_r <= {16'h0, tail_r};
        `DQ_REG_HEAD: reg_rdata_r <= {16'h0, head_r};
        `DQ_REG_COMPLETED: reg_rdata_r <= {16'h0, completed_r};
        `DQ_REG_CONS_LO: reg_rdata_r <= cons_r[31:0];
        `DQ_REG_CONS_HI: reg_rdata_r <= cons_r[63:32];
        `DQ_REG_PAYLOAD: reg_rdata_r <= stream_fixed_payload_size;
        default: reg_rdata_r <= 32'h0;
      endcase
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= `DQ_CTRL_RESET;
      base_r <= 64'h0;
      cons_r <= 64'h0;
      tail_r <= 16'h0;
      tail_seen_r <= 1'b0;
      stream_fixed_payload_size <= `DQ_PAYLOAD_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `DQ_REG_CTRL: ctrl_r <= reg_wdata[5:0];
        `DQ_REG_BASE_LO: base_r[31:0] <= reg_wdata;
        `DQ_REG_BASE_HI: base_r[63:32] <= reg_wdata;
        `DQ_REG_CONS_LO: cons_r[31:0] <= reg_wdata;
        `DQ_REG_CONS_HI: cons_r[63:32] <= reg_wdata;
        `DQ_REG_PAYLOAD: stream_fixed_payload_size <= reg_wdata;
        `DQ_REG_TAIL: begin
          tail_r <= reg_wdata[15:0];
          tail_seen_r <= 1'b1;
        end
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // ==========================================================
  // Descriptor sequencer
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      head_r <= 16'h0;
      completed_r <= 16'h0;
      cur_addr_r <= 64'h0;
      desc_r <= 256'h0;
      desc_rd_valid_r <= 1'b0;
      desc_rd_addr_r <= 64'h0;
      xfer_valid_r <= 1'b0;
      xfer_src_r <= 64'h0;
      xfer_dst_r <= 64'h0;
      xfer_len_r <= 21'h0;
      mwr_valid_r <= 1'b0;
      mwr_addr_r <= 64'h0;
      mwr_data_r <= 32'h0;
      msix_req_r <= 1'b0;
      msix_done_r <= 1'b0;
      remain_r <= 21'h0;
      rx_cnt_r <= 21'h0;
      first_beat_r <= 1'b0;
      pkt_open_r <= 1'b0;
      upd_sof_r <= 1'b0;
      end_by_last_r <= 1'b0;
      drop_r <= 1'b0;
      d2h_metadata_r <= 64'h0;
    end else begin
      if (d2h_drop_fire) begin
        drop_r <= !upstream_stream_last_beat;
      end
      case (state_r)
        ST_IDLE: begin
          // A disabled queue rewinds to its base so the ring restarts cleanly.
          if (!en) begin
            cur_addr_r <= base_r;
            head_r <= 16'h0;
            pkt_open_r <= 1'b0;
          end else if (head_r != tail_r) begin
            desc_rd_valid_r <= 1'b1;
            desc_rd_addr_r <= cur_addr_r;
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (desc_rd_ready) begin
            desc_rd_valid_r <= 1'b0;
            state_r <= ST_WAITD;
          end
        end
        ST_WAITD: begin
          if (desc_in_valid) begin
            desc_r <= desc_in_data;
            state_r <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          // A stale entry is left alone and fetched again later.
          if (is_stale) begin
            state_r <= ST_IDLE;
          end else if (is_link) begin
            cur_addr_r <= f_src;
            state_r <= ST_IDLE;
          end else begin
            xfer_valid_r <= 1'b1;
            xfer_src_r <= f_src;
            xfer_dst_r <= f_dst;
            xfer_len_r <= f_len;
            remain_r <= f_len;
            rx_cnt_r <= 21'h0;
            first_beat_r <= 1'b1;
            d2h_metadata_r <= f_meta;
            state_r <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (xfer_ready) begin
            xfer_valid_r <= 1'b0;
            if (!stream) begin
              state_r <= ST_MM;
            end else if (d2h) begin
              state_r <= ST_DWAIT;
            end else begin
              state_r <= ST_H2D;
            end
          end
        end
        ST_MM: begin
          if (xfer_done) begin
            completed_r <= f_id;
            state_r <= ST_WB;
          end
        end
        ST_H2D: begin
          if (h2d_fire) begin
            first_beat_r <= 1'b0;
            remain_r <= remain_r - BEAT;
            if (remain_r <= BEAT) begin
              completed_r <= f_id;
              state_r <= ST_WB;
            end
          end
        end
        ST_DWAIT: begin
          // Only the first data of a packet triggers the start-flag update.
          if (d2h_user_valid && !drop_now) begin
            if (!pkt_open_r) begin
              upd_sof_r <= 1'b1;
              state_r <= ST_DUPD;
            end else begin
              state_r <= ST_DDATA;
            end
          end
        end
        ST_DDATA: begin
          if (d2h_fire) begin
            rx_cnt_r <= rx_next;
            if (upstream_stream_last_beat || rx_next >= remain_r) begin
              end_by_last_r <= upstream_stream_last_beat;
              pkt_open_r <= !upstream_stream_last_beat;
              completed_r <= f_id;
              upd_sof_r <= 1'b0;
              state_r <= upstream_stream_last_beat ? ST_DUPD : ST_WB;
            end
          end
        end
        ST_DUPD: begin
          // Flags word is rebuilt from the fetched copy so reserved bits survive.
          if (!mwr_valid_r) begin
            mwr_valid_r <= 1'b1;
            mwr_addr_r <= cur_addr_r + `DQ_DESC_FLAGS_OFS;
            mwr_data_r <= {!upd_sof_r && end_by_last_r, upd_sof_r || f_sof,
              f_rsv, upd_sof_r ? 20'h0 : rx_cnt_r[19:0]};
          end else if (mwr_ready) begin
            mwr_valid_r <= 1'b0;
            state_r <= ST_WB;
          end
        end
        ST_WB: begin
          if (!wb_on) begin
            state_r <= ST_MSI;
          end else if (!mwr_valid_r) begin
            mwr_valid_r <= 1'b1;
            mwr_addr_r <= cons_r;
            mwr_data_r <= {16'h0, f_id};
          end else if (mwr_ready) begin
            mwr_valid_r <= 1'b0;
            state_r <= ST_MSI;
          end
        end
        ST_MSI: begin
          if (irq_on && !msix_done_r) begin
            msix_req_r <= 1'b1;
            if (msix_req_r && msix_ack) begin
              msix_req_r <= 1'b0;
              msix_done_r <= 1'b1;
            end
          end else begin
            msix_done_r <= 1'b0;
            if (upd_sof_r) begin
              upd_sof_r <= 1'b0;
              pkt_open_r <= 1'b1;
              state_r <= ST_DDATA;
            end else begin
              state_r <= ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          head_r <= head_r + 16'h0001;
          cur_addr_r <= cur_addr_r + `DQ_DESC_BYTES;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// ==== dv/dq_engine_asserts.sv ====
// Port-level checker for the queue engine.
`timescale 1ns/1ps
module dq_engine_asserts #(
  parameter DATA_W = 256
) (
  input wire clk_sys,
  input wire reset_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata_r,
  input wire desc_rd_valid_r,
  input wire desc_rd_ready,
  input wire [63:0] desc_rd_addr_r,
  input wire xfer_valid_r,
  input wire xfer_ready,
  input wire [20:0] xfer_len_r,
  input wire mwr_valid_r,
  input wire mwr_ready,
  input wire [63:0] mwr_addr_r,
  input wire [31:0] mwr_data_r,
  input wire msix_req_r,
  input wire msix_ack,
  input wire h2d_user_valid,
  input wire h2d_user_ready,
  input wire [DATA_W-1:0] h2d_user_data,
  input wire downstream_stream_last_beat
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Handshakes
  a_fetch_held: assert property (desc_rd_valid_r && !desc_rd_ready |=>
    desc_rd_valid_r && $stable(desc_rd_addr_r)) else $error("fetch not held");
  a_fetch_gap: assert property (desc_rd_valid_r && desc_rd_ready |=>
    !desc_rd_valid_r) else $error("fetch not dropped");
  a_xfer_held: assert property (xfer_valid_r && !xfer_ready |=>
    xfer_valid_r && $stable(xfer_len_r)) else $error("command not held");
  a_len_range: assert property (xfer_valid_r |->
    xfer_len_r != 21'h0 && xfer_len_r <= 21'h10_0000) else $error("bad length");
  a_mwr_held: assert property (mwr_valid_r && !mwr_ready |=>
    mwr_valid_r && $stable({mwr_addr_r, mwr_data_r})) else $error("write not held");
  a_irq_held: assert property (msix_req_r && !msix_ack |=> msix_req_r)
    else $error("irq not held");
  a_payload_readback: assert property (reg_wr && reg_addr == 8'h44 ##2
    reg_rd && reg_addr == 8'h44 |=> reg_rdata_r == $past(reg_wdata, 3))
    else $error("payload readback");
  a_h2d_beat_hold: assert property (h2d_user_valid && !h2d_user_ready |=>
    h2d_user_valid && $stable({h2d_user_data, downstream_stream_last_beat}))
    else $error("beat not held");
  c_irq: cover property (msix_req_r && msix_ack);
  c_mwr: cover property (mwr_valid_r && mwr_ready);
  c_last: cover property (h2d_user_valid && h2d_user_ready && downstream_stream_last_beat);
endmodule
bind dma_descriptor_queue_engine dq_engine_asserts #(.DATA_W(DATA_W)) i_dq_engine_asserts (.*);

// ==== dv/host_mdl.sv ====
// Host memory and data mover model for the queue engine.
`timescale 1ns/1ps
module host_mdl (
  input wire clk_sys,
  input wire reset_n,
  input wire mm_mode,
  input wire h2d_mode,
  input wire desc_rd_valid_r,
  output wire desc_rd_ready,
  input wire [63:0] desc_rd_addr_r,
  output logic desc_in_valid,
  output logic [255:0] desc_in_data,
  input wire xfer_valid_r,
  output wire xfer_ready,
  input wire [63:0] xfer_src_r,
  input wire [63:0] xfer_dst_r,
  input wire [20:0] xfer_len_r,
  output logic xfer_done,
  input wire mwr_valid_r,
  output wire mwr_ready,
  input wire [63:0] mwr_addr_r,
  input wire [31:0] mwr_data_r,
  input wire msix_req_r,
  output logic msix_ack,
  output logic h2d_in_valid,
  input wire h2d_in_ready,
  output logic [255:0] h2d_in_data
);
  logic [255:0] mem [logic [63:0]];
  logic [148:0] xq[$];
  logic [95:0] wq[$];
  logic slow;
  int irqs, left, wait_done;
  // Responders answer on alternate cycles only, so requests must be held.
  assign desc_rd_ready = desc_rd_valid_r & slow;
  assign xfer_ready = xfer_valid_r & slow;
  assign mwr_ready = mwr_valid_r & slow;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slow <= 1'b0;
      desc_in_valid <= 1'b0;
      desc_in_data <= '0;
      xfer_done <= 1'b0;
      msix_ack <= 1'b0;
      h2d_in_valid <= 1'b0;
      h2d_in_data <= '0;
      left = 0;
      wait_done <= 0;
      irqs <= 0;
    end else begin
      slow <= ~slow;
      desc_in_valid <= desc_rd_ready;
      // Between returns the bus shows garbage, not the last descriptor.
      desc_in_data <= desc_rd_ready ? mem[desc_rd_addr_r] : ~desc_in_data;
      msix_ack <= msix_req_r & ~msix_ack;
      if (msix_req_r && msix_ack) irqs <= irqs + 1;
      if (mwr_ready) wq.push_back({mwr_addr_r, mwr_data_r});
      xfer_done <= (wait_done == 1);
      if (wait_done != 0) wait_done <= wait_done - 1;
      if (h2d_in_valid && h2d_in_ready) begin
        left = left - 1;
        h2d_in_data <= h2d_in_data + 1;
      end
      if (xfer_ready) begin
        xq.push_back({xfer_len_r, xfer_dst_r, xfer_src_r});
        if (mm_mode) wait_done <= 3;
        else if (h2d_mode) left = (xfer_len_r + 31) / 32;
      end
      h2d_in_valid <= (left != 0);
    end
  end
endmodule

// ==== dv/dma_descriptor_queue_engine_tb.sv ====
// Self-checking bench for the queue engine.
`timescale 1ns/1ps
module dma_descriptor_queue_engine_tb;
  logic clk_sys, reset_n, reg_wr, reg_rd, stall, d2h_user_valid, upstream_stream_last_beat;
  logic mm_mode, h2d_mode;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, rv;
  logic [255:0] d2h_user_data;
  wire h2d_user_ready = stall;
  wire d2h_out_ready = stall;
  wire [31:0] reg_rdata_r, mwr_data_r;
  wire desc_rd_valid_r, desc_rd_ready, desc_in_valid, xfer_valid_r, xfer_ready, xfer_done;
  wire mwr_valid_r, mwr_ready, msix_req_r, msix_ack, h2d_in_valid, h2d_in_ready;
  wire h2d_user_valid, h2d_user_sop, downstream_stream_last_beat, d2h_user_ready, d2h_out_valid;
  wire [63:0] desc_rd_addr_r, xfer_src_r, xfer_dst_r, mwr_addr_r, h2d_user_metadata;
  wire [63:0] d2h_metadata_r;
  wire [255:0] desc_in_data, h2d_in_data, h2d_user_data, d2h_out_data;
  wire [20:0] xfer_len_r;
  int num_errors, n_tests, n_out;
  logic [9:0] bq[$];
  dma_descriptor_queue_engine i_dma_descriptor_queue_engine (.*);
  host_mdl i_host_mdl (.*);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [159:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys) #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys) #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk_sys) #1;
    reg_rd = 1'b0;
    rv = reg_rdata_r;
  endtask
  task automatic wait_head(input logic [31:0] h);
    int k;
    for (k = 0; k < 400; k++) begin
      rd(8'h14);
      if (rv === h) break;
    end
    if (k >= 400) begin
      num_errors++;
      $display("BAD head expected %h seen %h", h, rv);
      give_verdict;
    end
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic rst;
    reset_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    bq.delete();
    n_out = 0;
    i_host_mdl.wq.delete();
    i_host_mdl.xq.delete();
  endtask
  task automatic setup(input logic [31:0] c, input logic mm, input logic h2d);
    mm_mode = mm;
    h2d_mode = h2d;
    wr(8'h08, 32'h1000);
    wr(8'h20, 32'h3000);
    wr(8'h44, 32'h80);
    wr(8'h00, c);
  endtask
  // Flags f: link, stale, end, start, wb enable, irq enable.
  function automatic logic [255:0] mk(input logic [5:0] f, input logic [15:0] id,
    input logic [19:0] len, input logic [63:0] src);
    mk = '0;
    mk[63:0] = src;
    mk[127:64] = src + 64'h1;
    mk[147:128] = len;
    mk[175:160] = id;
    mk[177:176] = f[1:0];
    mk[223:222] = f[3:2];
    mk[255:254] = f[5:4];
  endfunction
  task automatic send(input int n);
    int k;
    d2h_user_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      d2h_user_data = i;
      upstream_stream_last_beat = (i == n - 1);
      k = 0;
      do begin
        @(negedge clk_sys);
        k++;
      end while (!d2h_user_ready && k < 300);
      if (k >= 300) begin
        num_errors++;
        $display("BAD upstream ready expected 1 seen 0");
        give_verdict;
      end
      @(posedge clk_sys) #1;
    end
    d2h_user_valid = 1'b0;
    upstream_stream_last_beat = 1'b0;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rst;
    rd(8'h00);
    chk("ctrl", 0, rv);
    wr(8'h44, 32'h80);
    rd(8'h44);
    chk("payload", 32'h80, rv);
    wr(8'h14, 32'h5);
    rd(8'h14);
    chk("head", 0, rv);
    wr(8'h30, 32'hffff_ffff);
    rd(8'h30);
    chk("unmapped", 0, rv);
    $display("regs done");
  endtask
  task automatic t_h2d;
    rst;
    i_host_mdl.mem[64'h1000] = mk(6'h0f, 16'h1, 20'h40, 64'ha000);
    i_host_mdl.mem[64'h1020] = mk(6'h20, 16'h0, 20'h0, 64'h2000);
    i_host_mdl.mem[64'h2000] = mk(6'h08, 16'h2, 20'h20, 64'hb000);
    i_host_mdl.mem[64'h2020] = mk(6'h20, 16'h0, 20'h0, 64'h1000);
    setup(32'h17, 1'b0, 1'b1);
    wr(8'h10, 32'h2);
    wait_head(2);
    chk("beat0", 10'h200, bq[0]);
    chk("beat1", 10'h101, bq[1]);
    chk("beat2", 10'h102, bq[2]);
    chk("beats", 3, bq.size());
    chk("cmd0", {21'h40, 64'ha001, 64'ha000}, i_host_mdl.xq[0]);
    chk("cmd1", {21'h20, 64'hb001, 64'hb000}, i_host_mdl.xq[1]);
    chk("wb", {64'h3000, 32'h1}, i_host_mdl.wq[0]);
    chk("writes", 1, i_host_mdl.wq.size());
    chk("irqs", 1, i_host_mdl.irqs);
    chk("meta", 0, h2d_user_metadata);
    rd(8'h18);
    chk("completed", 2, rv);
    $display("h2d done");
  endtask
  task automatic t_mm;
    rst;
    i_host_mdl.mem[64'h1000] = mk(6'h03, 16'h1, 20'h0, 64'hc000);
    i_host_mdl.mem[64'h1020] = mk(6'h10, 16'h2, 20'h40, 64'hd000);
    setup(32'h03, 1'b1, 1'b1);
    wr(8'h10, 32'h2);
    wait_head(1);
    repeat (40) @(posedge clk_sys);
    rd(8'h14);
    chk("head stale", 1, rv);
    rd(8'h18);
    chk("completed", 1, rv);
    i_host_mdl.mem[64'h1020] = mk(6'h00, 16'h2, 20'h40, 64'hd000);
    wait_head(2);
    chk("len zero", {21'h10_0000, 64'hc001, 64'hc000}, i_host_mdl.xq[0]);
    chk("writes", 0, i_host_mdl.wq.size());
    chk("irqs", 1, i_host_mdl.irqs);
    $display("mm done");
  endtask
  task automatic t_d2h;
    rst;
    i_host_mdl.mem[64'h1000] = mk(6'h02, 16'h1, 20'h80, 64'h1234);
    setup(32'h3d, 1'b0, 1'b0);
    send(2);
    chk("dropped", 0, n_out);
    wr(8'h10, 32'h1);
    send(2);
    wait_head(1);
    chk("beats", 2, n_out);
    chk("start", {64'h1018, 32'h4000_0000}, i_host_mdl.wq[0]);
    chk("wb0", {64'h3000, 32'h1}, i_host_mdl.wq[1]);
    chk("end", {64'h1018, 32'h8000_0040}, i_host_mdl.wq[2]);
    chk("wb1", {64'h3000, 32'h1}, i_host_mdl.wq[3]);
    chk("meta", 64'h1234, d2h_metadata_r);
    $display("d2h done");
  endtask
  always @(posedge clk_sys) begin
    stall <= #1 ~stall;
    if (h2d_user_valid && h2d_user_ready)
      bq.push_back({h2d_user_sop, downstream_stream_last_beat, h2d_user_data[7:0]});
    if (d2h_out_valid && d2h_out_ready) n_out++;
  end
  initial begin
    #500000;
    num_errors++;
    $display("BAD run expected end seen hang");
    give_verdict;
  end
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    stall = 1'b0;
    d2h_user_valid = 1'b0;
    upstream_stream_last_beat = 1'b0;
    num_errors = 0;
    n_tests = 0;
    t_regs;
    t_h2d;
    t_mm;
    t_d2h;
    give_verdict;
  end
endmodule
